// ==== design/lccd_ctrl.sv ====
// Timing generator and video capture for a 2048-pixel linear image sensor
//
// Behaviour
// - Interval between transfer pulses sets exposure time.
// - Transfer pulses at least 2081 output sample clock periods apart.
// - Output sample clock runs at exactly twice the shift phase clock.
// - One sample per output sample clock; that clock at most 10 MHz.
// - White-reference inject clock runs at the transfer pulse rate.
// - Holding inject clock high suppresses white reference and scan-done.
// - Output sample clock runs continuously; phase clock divides it by two. A full FIFO here stops both.
// - Phase clock keeps running after readout ends.
// - Transfer and inject clocks are integer submultiples of phase clock.
// - Transfer pulse rises 0 to 50 ns after phase clock rise.
// - Inject clock falls 0 to 50 ns after phase clock rise.
// - Output sample clock rises no earlier than phase clock rise.
// - Output sample clock high for at least 40 ns.
// - Transfer pulse falls at least 50 ns after phase clock fall.
// - Inject clock rises 0 to 50 ns after phase clock fall.
// - At least 50 ns from transfer fall to next phase clock rise.
`timescale 1ns/1ns

module lccd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign out_data_out  = mem[rd_ptr_r];

  always_ff @(posedge clock_in)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : lccd_fifo

module lccd_ctrl
  import lccd_pkg::*;
(
  input  wire logic                    clock_in,
  input  wire logic                    rst_in,
  input  wire logic                    run_in,
  input  wire logic                    whiteref_enable_in,
  input  wire logic [`LCCD_LINE_W-1:0] line_period_in,
  input  wire logic                    scan_done_pulse_in,
  input  wire logic [`LCCD_LEVEL_W-1:0] video_level_in,
  output logic                         transfer_pulse_out,
  output logic                         transport_clock_out,
  output logic                         output_sample_clock_out,
  output logic                         whiteref_inject_clock_out,
  output logic                         line_start_out,
  output logic                         scan_done_out,
  output logic                         sample_valid_out,
  input  wire logic                    sample_ready_in,
  output lccd_sample_s                 sample_out
);
  localparam int SW = $bits(lccd_sample_s);
  localparam logic [`LCCD_LINE_W-1:0] MIN_LEN = `LCCD_LINE_W'(`LCCD_MIN_TCK_PER_LINE);

  logic [`LCCD_DIV_W-1:0]   div_cnt_r;
  logic                     step;
  logic                     fifo_ready;
  lccd_phase_e              phase_r;
  lccd_phase_e              phase_nxt;
  logic [`LCCD_LINE_W-1:0]  tck_cnt_r;
  logic [`LCCD_LINE_W-1:0]  tck_cnt_nxt;
  logic [`LCCD_LINE_W-1:0]  line_len_r;
  logic                     xfer_line_r;
  logic                     xfer_line_nxt;
  logic                     run_sync1_r;
  logic                     run_r;
  logic                     wr_sync1_r;
  logic                     wr_r;
  logic                     eos_sync1_r;
  logic                     eos_sync2_r;
  logic                     eos_prev_r;
  logic [`LCCD_LEVEL_W-1:0] lvl_sync1_r;
  logic [`LCCD_LEVEL_W-1:0] lvl_sync2_r;
  logic [`LCCD_IDX_W-1:0]   idx_r;
  logic                     capturing_r;
  logic                     eos_seen_r;
  logic                     eos_edge;
  logic                     push;
  lccd_sample_s             push_data;
  logic [SW-1:0]            pop_bits;

  // A full FIFO freezes every driven clock rather than dropping pixels
  assign step = (div_cnt_r == `LCCD_DIV_W'(`LCCD_STEP_CYC - 1)) & fifo_ready;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_cnt_r <= '0;
    end
    else if (div_cnt_r == `LCCD_DIV_W'(`LCCD_STEP_CYC - 1))
    begin
      if (fifo_ready)
      begin
        div_cnt_r <= '0;
      end
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  // Control levels from outside pass two flip-flops; line_period_in is latched directly
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      run_sync1_r <= 1'b0;
      run_r       <= 1'b0;
      wr_sync1_r  <= 1'b0;
      wr_r        <= 1'b0;
      eos_sync1_r <= 1'b0;
      eos_sync2_r <= 1'b0;
      eos_prev_r  <= 1'b0;
      lvl_sync1_r <= '0;
      lvl_sync2_r <= '0;
    end
    else
    begin
      run_sync1_r <= run_in;
      run_r       <= run_sync1_r;
      wr_sync1_r  <= whiteref_enable_in;
      wr_r        <= wr_sync1_r;
      eos_sync1_r <= scan_done_pulse_in;
      eos_sync2_r <= eos_sync1_r;
      eos_prev_r  <= eos_sync2_r;
      lvl_sync1_r <= video_level_in;
      lvl_sync2_r <= lvl_sync1_r;
    end
  end

  always_comb
  begin
    unique case (phase_r)
      PH_TH_A: phase_nxt = PH_TH_B;
      PH_TH_B: phase_nxt = PH_TL_A;
      PH_TL_A: phase_nxt = PH_TL_B;
      PH_TL_B: phase_nxt = PH_TH_A;
    endcase
  end

  // Line counter advances once per phase clock period
  always_comb
  begin
    tck_cnt_nxt   = tck_cnt_r;
    xfer_line_nxt = xfer_line_r;
    if (phase_nxt == PH_TH_A)
    begin
      if (tck_cnt_r >= line_len_r - 1'b1)
      begin
        tck_cnt_nxt = '0;
      end
      else
      begin
        tck_cnt_nxt = tck_cnt_r + 1'b1;
      end
      xfer_line_nxt = (tck_cnt_nxt == '0) && run_r;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_r     <= PH_TL_B;
      tck_cnt_r   <= '0;
      xfer_line_r <= 1'b0;
    end
    else if (step)
    begin
      phase_r     <= phase_nxt;
      tck_cnt_r   <= tck_cnt_nxt;
      xfer_line_r <= xfer_line_nxt;
    end
  end

  // Period latched once per line, never below full readout
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      line_len_r <= MIN_LEN;
    end
    else if (step && phase_nxt == PH_TH_A && tck_cnt_nxt == '0)
    begin
      line_len_r <= (line_period_in < MIN_LEN) ? MIN_LEN : line_period_in;
    end
  end

  // Pin clocks: all edges move on steps; paired edges coincide except transfer fall, one step after phase fall
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      transport_clock_out       <= 1'b0;
      output_sample_clock_out   <= 1'b0;
      transfer_pulse_out        <= 1'b0;
      whiteref_inject_clock_out <= 1'b1;
      line_start_out            <= 1'b0;
    end
    else
    begin
      line_start_out <= step && phase_nxt == PH_TH_A && xfer_line_nxt;
      if (step)
      begin
        // Phase clock keeps running whatever run_in says
        transport_clock_out <= (phase_nxt == PH_TH_A) || (phase_nxt == PH_TH_B);
        // Twice the phase rate, one step high, rising with phase clock
        output_sample_clock_out <= (phase_nxt == PH_TH_A) || (phase_nxt == PH_TL_A);
        // Rises with phase clock, falls one step after its fall
        transfer_pulse_out <= xfer_line_nxt && (phase_nxt != PH_TL_B);
        // Low over the transfer period's high half
        whiteref_inject_clock_out <= !(wr_r && xfer_line_nxt &&
                                       ((phase_nxt == PH_TH_A) || (phase_nxt == PH_TH_B)));
      end
    end
  end

  // One sample per output sample clock in arrival order
  assign push = step && capturing_r && ((phase_r == PH_TH_B) || (phase_r == PH_TL_B));
  assign push_data.index     = idx_r;
  assign eos_edge            = eos_sync2_r & ~eos_prev_r;
  assign push_data.scan_done = eos_seen_r | eos_edge;
  assign push_data.level     = lvl_sync2_r;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      idx_r       <= '0;
      capturing_r <= 1'b0;
    end
    else if (step && phase_nxt == PH_TH_A && xfer_line_nxt)
    begin
      idx_r       <= '0;
      capturing_r <= 1'b1;
    end
    else if (push)
    begin
      idx_r <= idx_r + 1'b1;
      // Whole readout incl. black and white references
      if (idx_r == `LCCD_IDX_W'(`LCCD_MIN_RCK_PER_LINE - 1))
      begin
        capturing_r <= 1'b0;
      end
    end
  end

  // Scan-done edge marks the sample that carries the first white reference
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      eos_seen_r    <= 1'b0;
      scan_done_out <= 1'b0;
    end
    else
    begin
      scan_done_out <= eos_edge;
      // The edge lines up with the white sample's push; a late one rides the next push
      eos_seen_r    <= !push && (eos_seen_r || eos_edge);
    end
  end

  lccd_fifo #(
    .WIDTH (SW),
    .DEPTH (`LCCD_FIFO_DEPTH),
    .AW    (`LCCD_FIFO_AW)
  ) u_fifo (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (push_data),
    .out_valid_out (sample_valid_out),
    .out_ready_in  (sample_ready_in),
    .out_data_out  (pop_bits)
  );

  assign sample_out = lccd_sample_s'(pop_bits);
endmodule : lccd_ctrl

// ==== inc/lccd_consts.svh ====
// Timing and geometry constants for the linear sensor timing generator
`ifndef LCCD_CONSTS_SVH
`define LCCD_CONSTS_SVH
`define LCCD_CLK_NS           50
`define LCCD_RCK_MAX_MHZ      10
`define LCCD_RCK_MIN_PER_NS   (1000 / `LCCD_RCK_MAX_MHZ)
`define LCCD_CYC_PER_RCK      ((`LCCD_RCK_MIN_PER_NS + `LCCD_CLK_NS - 1) / `LCCD_CLK_NS)
`define LCCD_STEP_CYC         (`LCCD_CYC_PER_RCK / 2)
`define LCCD_RCK_HIGH_MIN_NS  40
`define LCCD_XLTH_MIN_NS      50
`define LCCD_TLXL_MIN_NS      50
`define LCCD_MIN_RCK_PER_LINE 2081
`define LCCD_MIN_TCK_PER_LINE ((`LCCD_MIN_RCK_PER_LINE + 1) / 2)
`define LCCD_PIXELS           2048
`define LCCD_DIV_W            4
`define LCCD_LINE_W           16
`define LCCD_IDX_W            12
`define LCCD_LEVEL_W          8
`define LCCD_FIFO_DEPTH       8
`define LCCD_FIFO_AW          3
`endif

// ==== inc/lccd_pkg.sv ====
// Types shared by the linear sensor timing generator
`include "lccd_consts.svh"
package lccd_pkg;
  // Quarter steps of one transport clock period
  typedef enum logic [1:0] {
    PH_TH_A,
    PH_TH_B,
    PH_TL_A,
    PH_TL_B
  } lccd_phase_e;

  typedef struct packed {
    logic [`LCCD_IDX_W-1:0]   index;
    logic                     scan_done;
    logic [`LCCD_LEVEL_W-1:0] level;
  } lccd_sample_s;
endpackage : lccd_pkg

// ==== verif/lccd_ctrl_sva.sv ====
// Checker for the generated sensor clocks and the sample stream
`timescale 1ns/1ns
module lccd_ctrl_sva
  import lccd_pkg::*;
(
  input wire logic         clock_in,
  input wire logic         rst_in,
  input wire logic         transfer_pulse_out,
  input wire logic         transport_clock_out,
  input wire logic         output_sample_clock_out,
  input wire logic         whiteref_inject_clock_out,
  input wire logic         line_start_out,
  input wire logic         sample_valid_out,
  input wire logic         sample_ready_in,
  input wire lccd_sample_s sample_out
);
  logic [19:0] gap_r;
  logic        seen_r;
  // A stalled generator only stretches the gap, so a lower bound is safe
  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      gap_r <= 20'h00000;
    else
      gap_r <= line_start_out ? 20'h00001 : gap_r + 20'h00001;
  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      seen_r <= 1'b0;
    else
      seen_r <= seen_r | line_start_out;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  a_xfer_rise: assert property (
    line_start_out |-> $rose(transfer_pulse_out) && $rose(transport_clock_out))
    else $error("transfer rise apart from transport rise");
  a_xfer_fall: assert property (
    $fell(transfer_pulse_out) |-> !transport_clock_out && !$past(transport_clock_out))
    else $error("transfer fell too soon after transport fall");
  a_xfer_gap: assert property (
    $rose(transport_clock_out) |-> !$past(transfer_pulse_out))
    else $error("transport rose too soon after transfer fall");
  a_inject_fall: assert property (
    $fell(whiteref_inject_clock_out) |-> line_start_out && $rose(transport_clock_out))
    else $error("inject fell outside a line start");
  a_inject_rise: assert property (
    $rose(whiteref_inject_clock_out) |-> $fell(transport_clock_out))
    else $error("inject rose apart from transport fall");
  a_smp_pair: assert property (
    $changed(transport_clock_out) |-> $rose(output_sample_clock_out))
    else $error("sample clock not twice transport rate");
  a_line_gap: assert property (
    line_start_out && seen_r |-> gap_r >= 20'h01044)
    else $error("line starts too close");
  a_hold_sample: assert property (
    sample_valid_out && !sample_ready_in |=> sample_valid_out && $stable(sample_out))
    else $error("sample dropped while stalled");
endmodule : lccd_ctrl_sva
bind lccd_ctrl lccd_ctrl_sva chk_u (
  .clock_in(clock_in),
  .rst_in(rst_in),
  .transfer_pulse_out(transfer_pulse_out),
  .transport_clock_out(transport_clock_out),
  .output_sample_clock_out(output_sample_clock_out),
  .whiteref_inject_clock_out(whiteref_inject_clock_out),
  .line_start_out(line_start_out),
  .sample_valid_out(sample_valid_out),
  .sample_ready_in(sample_ready_in),
  .sample_out(sample_out)
);

// ==== verif/lccd_sensor_model.sv ====
// Behavioural line sensor answering the generated clocks
`timescale 1ns/1ns
module lccd_sensor_model
(
  input  wire logic  clock_in,
  input  wire logic  transfer_in,
  input  wire logic  sample_clock_in,
  input  wire logic  inject_in,
  output logic       scan_done_out,
  output logic [7:0] video_out
);
  logic [11:0] pos_r   = 12'hfff;
  logic        white_r = 1'b0;
  logic        smp_q   = 1'b0;
  logic        xfer_q  = 1'b0;
  initial scan_done_out = 1'b0;
  initial video_out = 8'h00;
  // Pins are seen through the system clock; the sensor has no clock of its own
  always @(posedge clock_in)
  begin
    smp_q  <= sample_clock_in;
    xfer_q <= transfer_in;
    if (transfer_in && !xfer_q)
    begin
      pos_r   <= 12'h000;
      white_r <= !inject_in;
    end
    else if (sample_clock_in && !smp_q && pos_r != 12'hfff)
    begin
      pos_r         <= pos_r + 12'h001;
      if (white_r && (pos_r == 12'h808 || pos_r == 12'h809))
        video_out <= 8'hff;
      else if (pos_r < 12'h004 || pos_r > 12'h803)
        video_out <= 8'h00;
      else
        video_out <= {1'b0, pos_r[6:0]};
      scan_done_out <= white_r && pos_r == 12'h808;
    end
  end
endmodule : lccd_sensor_model

// ==== verif/testbench.sv ====
// Self-checking bench for the sensor timing generator
`timescale 1ns/1ns
module testbench
  import lccd_pkg::*;
;
  logic         clock_in = 1'b0;
  logic         rst_in, run_in, whiteref_enable_in, sample_ready_in;
  logic [15:0]  line_period_in;
  logic         sd_w, xfer_w, tport_w, smp_w, inj_w, ls_w, done_w, valid_w;
  logic [7:0]   level_w;
  lccd_sample_s sample_w;
  logic [31:0]  last_idx;
  logic [7:0]   exp_lvl;
  logic         lvl_chk = 1'b0;
  int           errors, samples_checked, whites, dones, cyc;
  initial forever #25 clock_in = ~clock_in;
  lccd_ctrl dut_u (.clock_in(clock_in), .rst_in(rst_in), .run_in(run_in),
    .whiteref_enable_in(whiteref_enable_in), .line_period_in(line_period_in),
    .scan_done_pulse_in(sd_w), .video_level_in(level_w), .transfer_pulse_out(xfer_w),
    .transport_clock_out(tport_w), .output_sample_clock_out(smp_w),
    .whiteref_inject_clock_out(inj_w), .line_start_out(ls_w), .scan_done_out(done_w),
    .sample_valid_out(valid_w), .sample_ready_in(sample_ready_in), .sample_out(sample_w));
  lccd_sensor_model sensor_u (.clock_in(clock_in), .transfer_in(xfer_w),
    .sample_clock_in(smp_w), .inject_in(inj_w), .scan_done_out(sd_w), .video_out(level_w));
  task automatic stop_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    samples_checked++;
    if (act !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : check
  // Sensor pattern; sensor position runs two samples behind captured index
  function automatic logic [7:0] exp_level(input logic [11:0] idx, input logic white);
    logic [11:0] pos;
    pos = idx - 12'h002;
    if (white && (pos == 12'h808 || pos == 12'h809))
      return 8'hff;
    if (pos < 12'h004 || pos > 12'h803)
      return 8'h00;
    return {1'b0, pos[6:0]};
  endfunction : exp_level
  // Stream monitor; the ceiling covers about thirteen lines plus the idle spell
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc > 60000)
    begin
      errors++;
      stop_test();
    end
    if (valid_w === 1'b1 && sample_ready_in === 1'b1)
    begin
      if (sample_w.index === 12'h000)
      begin
        whites = 0;
        dones = 0;
      end
      else
        check({20'h00000, sample_w.index}, last_idx + 32'h1);
      last_idx = {20'h00000, sample_w.index};
      whites += (sample_w.level === 8'hff);
      dones += (sample_w.scan_done === 1'b1);
      exp_lvl = exp_level(sample_w.index, whiteref_enable_in);
      if (lvl_chk && sample_w.index >= 12'h002)
        check({24'h000000, sample_w.level}, {24'h000000, exp_lvl});
      if (sample_w.scan_done === 1'b1)
        check({24'h000000, sample_w.level}, 32'h0000_00ff);
    end
  end
  task automatic run_line(input int exp_n, input int exp_w);
    int n;
    int inj;
    int scan_done_pulse;
    n = 0;
    inj = 0;
    scan_done_pulse = 0;
    do @(negedge clock_in); while (ls_w !== 1'b1);
    lvl_chk = 1'b1;
    do
    begin
      @(negedge clock_in);
      n++;
      inj += (inj_w === 1'b0);
      scan_done_pulse += (done_w === 1'b1);
    end
    while (ls_w !== 1'b1);
    lvl_chk = 1'b0;
    check(n, exp_n);
    check(scan_done_pulse, exp_w / 2);
    check(inj, exp_w);
    check(whites, exp_w);
    check(dones, exp_w / 2);
    check(last_idx, 32'h0000_0820);
  endtask : run_line
  task automatic t_clamp();
    run_line(32'h0000_1044, 2);
  endtask : t_clamp
  task automatic t_nowhite();
    @(posedge clock_in);
    whiteref_enable_in <= 1'b0;
    run_line(32'h0000_1044, 0);
  endtask : t_nowhite
  task automatic t_period();
    @(posedge clock_in);
    whiteref_enable_in <= 1'b1;
    line_period_in     <= 16'h044c;
    run_line(32'h0000_1130, 2);
  endtask : t_period
  task automatic t_stall();
    int   tog;
    logic p;
    tog = 0;
    @(posedge clock_in);
    sample_ready_in <= 1'b0;
    repeat (20) @(negedge clock_in);
    p = tport_w;
    repeat (40)
    begin
      @(negedge clock_in);
      tog += (tport_w !== p);
    end
    check(tog, 0);
    check(valid_w, 1);
    @(posedge clock_in);
    sample_ready_in <= 1'b1;
    run_line(32'h0000_1130, 2);
  endtask : t_stall
  task automatic t_idle();
    int   ls;
    int   tog;
    logic p;
    ls = 0;
    tog = 0;
    @(posedge clock_in);
    run_in <= 1'b0;
    @(negedge clock_in);
    p = tport_w;
    repeat (5000)
    begin
      @(negedge clock_in);
      ls += (ls_w === 1'b1);
      tog += (tport_w !== p);
      p = tport_w;
    end
    check(ls, 0);
    check(tog, 32'h0000_09c4);
  endtask : t_idle
  initial
  begin
    rst_in = 1'b1;
    run_in = 1'b1;
    whiteref_enable_in = 1'b1;
    line_period_in = 16'h0000;
    sample_ready_in = 1'b1;
    @(negedge clock_in);
    check({xfer_w, tport_w, smp_w, inj_w, valid_w}, 32'h2);
    @(posedge clock_in);
    rst_in <= 1'b0;
    t_clamp();
    t_nowhite();
    t_period();
    t_stall();
    t_idle();
    stop_test();
  end
endmodule : testbench
